//--- verilog/rfcw_top.sv
/*
  rfcw_top: serial-loaded control word bank of the transceiver.
  Assumes serial clock, data and load strobe arrive asynchronously from the
  host and are much slower than clk (link period 800 ns against 100 ns).
*/
// Function
// - rx reference divider from first word bits 9:0
// - tx reference divider from second word bits 9:0
// - rx feedback divider from third word 16:0
// - tx feedback divider from fourth word 16:0
// - first word bits 11:10 select active mode
// - first word bit 12 sets internal amp gain
// - first word bit 13 sets mixer gain
// - first word bits 15:14 set transmit power
// - first word bit 16 disables amp autostart
// - first word bit 17 sets lock analyse mode
// - first word bit 18 selects pump current
// - first word bit 19 selects ask or fsk
// - first word bit 20 inverts input data sense
// - second word holds oscillator current floor, ceiling
// - second word bit 19 enables delayed synth start
// - third word bits 19:18 select vco current
// - third word bit 20 sets detector polarity
// - third word bit 21 selects amp gain source
// - fourth word bits 18:17 set lock error window
// - fourth word bits 20:19 set lock settle count
// - fourth word bit 21 selects keying source
// - data sampled msb first on clock rise
// - load strobe rise copies frame to word
// - top two frame bits address the word
// - only last 24 shifted bits are kept
`timescale 1ns/1ns
module rfcw_top (
  input  wire logic                  clk,               // 10 MHz system clock
  input  wire logic                  nrst,              // async reset, active low
  input  wire logic                  serial_clock_line, // link clock from host
  input  wire logic                  serial_data_line,  // link data from host
  input  wire logic                  serial_load_strobe,// frame load strobe
  output rfcw_pkg::rfcw_rx_ref_s     rx_ref_cfg,        // first word fields
  output rfcw_pkg::rfcw_tx_ref_s     tx_ref_cfg,        // second word fields
  output rfcw_pkg::rfcw_rx_fb_s      rx_fb_cfg,         // third word fields
  output rfcw_pkg::rfcw_tx_fb_s      tx_fb_cfg,         // fourth word fields
  output rfcw_pkg::rfcw_mode_e       active_mode,       // decoded mode
  output logic                       amp_gain_int_high, // internal gain request
  output logic                       load_done          // pulse after a load
);
  // ==========================================================================
  // input synchronisers
  logic [rfcw_pkg::SYNC_DEPTH-1:0] sclk_sync_r;
  logic [rfcw_pkg::SYNC_DEPTH-1:0] sdat_sync_r;
  logic [rfcw_pkg::SYNC_DEPTH-1:0] sld_sync_r;
  logic                            sclk_prev_r;
  logic                            sld_prev_r;
  logic                            sclk_rise;
  logic                            sld_rise;

  // two stages per pin, only the last stage is read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_sync_r <= '0;
      sdat_sync_r <= '0;
      sld_sync_r  <= '0;
      sclk_prev_r <= 1'b0;
      sld_prev_r  <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], serial_clock_line};
      sdat_sync_r <= {sdat_sync_r[0], serial_data_line};
      sld_sync_r  <= {sld_sync_r[0], serial_load_strobe};
      sclk_prev_r <= sclk_sync_r[1];
      sld_prev_r  <= sld_sync_r[1];
    end
  end

  // edge detection on the synchronised link clock and load strobe lines
  assign sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
  assign sld_rise  = sld_sync_r[1] & ~sld_prev_r;

  // ==========================================================================
  // shift register
  logic [rfcw_pkg::FRAME_BITS-1:0] shift_r;
  logic [rfcw_pkg::FRAME_BITS-1:0] shift_nxt;

  // msb first, older leading bits fall off the top
  assign shift_nxt = {shift_r[rfcw_pkg::FRAME_BITS-2:0], sdat_sync_r[1]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= shift_nxt;
    end
  end

  // ==========================================================================
  // word latches
  logic [1:0]                       frame_addr;
  logic [rfcw_pkg::DATA_BITS-1:0]   frame_data;
  logic [rfcw_pkg::DATA_BITS-1:0]   word_r [rfcw_pkg::NUM_WORDS];

  assign frame_addr = shift_r[rfcw_pkg::ADDR_HI:rfcw_pkg::ADDR_LO];
  assign frame_data = shift_r[rfcw_pkg::DATA_BITS-1:0];

  // load strobe rise copies the whole data field, unused bits included
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < rfcw_pkg::NUM_WORDS; i++) begin
        word_r[i] <= rfcw_pkg::WORD_RESET;
      end
    end else if (sld_rise) begin
      word_r[frame_addr] <= frame_data;
    end
  end

  // ==========================================================================
  // field outputs, registered again so outputs leave flip-flops
  logic [rfcw_pkg::DATA_BITS-1:0] w0;
  logic [rfcw_pkg::DATA_BITS-1:0] w1;
  logic [rfcw_pkg::DATA_BITS-1:0] w2;
  logic [rfcw_pkg::DATA_BITS-1:0] w3;

  assign w0 = word_r[rfcw_pkg::ADDR_RX_REF];
  assign w1 = word_r[rfcw_pkg::ADDR_TX_REF];
  assign w2 = word_r[rfcw_pkg::ADDR_RX_FB];
  assign w3 = word_r[rfcw_pkg::ADDR_TX_FB];

  // first word: bit 21 dropped, it drives nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_ref_cfg <= '0;
    end else begin
      rx_ref_cfg.rx_ref_divider        <= w0[rfcw_pkg::REF_DIV_MSB:0];
      rx_ref_cfg.active_mode_field     <= w0[rfcw_pkg::MODE_LO +: 2];
      rx_ref_cfg.amp_gain_select       <= w0[rfcw_pkg::AMP_GAIN_BIT];
      rx_ref_cfg.mixer_gain_select     <= w0[rfcw_pkg::MIX_GAIN_BIT];
      rx_ref_cfg.tx_level_field        <= w0[rfcw_pkg::TX_LEVEL_LO +: 2];
      rx_ref_cfg.amp_autostart_disable <= w0[rfcw_pkg::AUTOSTART_BIT];
      rx_ref_cfg.lock_mode             <= w0[rfcw_pkg::LOCK_MODE_BIT];
      rx_ref_cfg.pump_current_select   <= w0[rfcw_pkg::PUMP_BIT];
      rx_ref_cfg.keying_select_pin_select        <= w0[rfcw_pkg::KEYING_BIT];
      rx_ref_cfg.input_data_sense      <= w0[rfcw_pkg::SENSE_BIT];
    end
  end

  // second word: test bits 16, 17 and bits 20, 21 have no effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ref_cfg <= '0;
    end else begin
      tx_ref_cfg.tx_ref_divider        <= w1[rfcw_pkg::REF_DIV_MSB:0];
      tx_ref_cfg.osc_current_floor     <= w1[rfcw_pkg::OSC_FLOOR_LO +: 3];
      tx_ref_cfg.osc_current_ceiling   <= w1[rfcw_pkg::OSC_CEIL_LO +: 3];
      tx_ref_cfg.amp_hysteresis_enable <= w1[rfcw_pkg::HYST_BIT];          // hysteresis choice
      tx_ref_cfg.synth_delayed_start   <= w1[rfcw_pkg::DELAY_BIT];
    end
  end

  // third and fourth words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_fb_cfg <= '0;
      tx_fb_cfg <= '0;
    end else begin
      rx_fb_cfg.rx_feedback_divider    <= w2[rfcw_pkg::FB_DIV_MSB:0];
      rx_fb_cfg.band_select            <= w2[rfcw_pkg::BAND_BIT];          // band choice
      rx_fb_cfg.vco_bias_level         <= w2[rfcw_pkg::VCO_BIAS_LO +: 2];
      rx_fb_cfg.phase_detector_sense   <= w2[rfcw_pkg::PD_SENSE_BIT];
      rx_fb_cfg.amp_gain_source        <= w2[rfcw_pkg::GAIN_SRC_BIT];
      tx_fb_cfg.tx_feedback_divider    <= w3[rfcw_pkg::FB_DIV_MSB:0];
      tx_fb_cfg.lock_error_window      <= w3[rfcw_pkg::ERR_WIN_LO +: 2];
      tx_fb_cfg.lock_settle_count      <= w3[rfcw_pkg::SETTLE_LO +: 2];
      tx_fb_cfg.keying_source_select   <= w3[rfcw_pkg::KEY_SRC_BIT];
    end
  end

  // decoded mode and internal gain request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_mode       <= rfcw_pkg::RFCW_STANDBY;
      amp_gain_int_high <= 1'b0;
      load_done         <= 1'b0;
    end else begin
      case (w0[rfcw_pkg::MODE_LO +: 2])
        rfcw_pkg::MODE_STANDBY:  active_mode <= rfcw_pkg::RFCW_STANDBY;
        rfcw_pkg::MODE_RECEIVE:  active_mode <= rfcw_pkg::RFCW_RECEIVE;
        rfcw_pkg::MODE_TRANSMIT: active_mode <= rfcw_pkg::RFCW_TRANSMIT;
        default:                 active_mode <= rfcw_pkg::RFCW_IDLE;
      endcase
      amp_gain_int_high <= w2[rfcw_pkg::GAIN_SRC_BIT] & w0[rfcw_pkg::AMP_GAIN_BIT];
      load_done         <= sld_rise;
    end
  end

  // ==========================================================================
  // assertions
  a_shift_msb_first: assert property (@(posedge clk) disable iff (!nrst)
    sclk_rise |=> shift_r[0] == $past(sdat_sync_r[1]))
    else $error("shift register did not take data bit");

  a_shift_keeps_last: assert property (@(posedge clk) disable iff (!nrst)
    sclk_rise |=> shift_r[rfcw_pkg::FRAME_BITS-1:1] == $past(shift_r[rfcw_pkg::FRAME_BITS-2:0]))
    else $error("shift register lost older bits");

  a_shift_hold: assert property (@(posedge clk) disable iff (!nrst)
    !sclk_rise |=> $stable(shift_r))
    else $error("shift register moved without clock edge");

  a_load_word: assert property (@(posedge clk) disable iff (!nrst)
    sld_rise |=> word_r[$past(frame_addr)] == $past(frame_data))
    else $error("addressed word not loaded");

  a_rx_ref_out: assert property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_RX_REF
      |=> ##1 rx_ref_cfg.rx_ref_divider == $past(frame_data[rfcw_pkg::REF_DIV_MSB:0], 2))
    else $error("rx reference divider not updated");

  a_tx_fb_out: assert property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_TX_FB
      |=> ##1 tx_fb_cfg.tx_feedback_divider == $past(frame_data[rfcw_pkg::FB_DIV_MSB:0], 2))
    else $error("tx feedback divider not updated");

  a_tx_ref_out: assert property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_TX_REF
      |=> ##1 tx_ref_cfg.tx_ref_divider == $past(frame_data[rfcw_pkg::REF_DIV_MSB:0], 2))
    else $error("tx reference divider not updated");

  a_rx_fb_out: assert property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_RX_FB
      |=> ##1 rx_fb_cfg.rx_feedback_divider == $past(frame_data[rfcw_pkg::FB_DIV_MSB:0], 2))
    else $error("rx feedback divider not updated");

  // ==========================================================================
  // field checks: each output field but amp_hysteresis_enable, band_select and amp_gain_source follows its latched word bits
  a_mode_field: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.active_mode_field == $past(w0[rfcw_pkg::MODE_LO +: 2]))
    else $error("mode field not carried to output");

  a_amp_gain: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.amp_gain_select == $past(w0[rfcw_pkg::AMP_GAIN_BIT]))
    else $error("amp gain bit not carried to output");

  a_mixer_gain: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.mixer_gain_select == $past(w0[rfcw_pkg::MIX_GAIN_BIT]))
    else $error("mixer gain bit not carried to output");

  a_tx_level: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.tx_level_field == $past(w0[rfcw_pkg::TX_LEVEL_LO +: 2]))
    else $error("transmit level not carried to output");

  a_autostart: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.amp_autostart_disable == $past(w0[rfcw_pkg::AUTOSTART_BIT]))
    else $error("autostart bit not carried to output");

  a_lock_mode: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.lock_mode == $past(w0[rfcw_pkg::LOCK_MODE_BIT]))
    else $error("lock mode bit not carried to output");

  a_pump_current: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.pump_current_select == $past(w0[rfcw_pkg::PUMP_BIT]))
    else $error("pump current bit not carried to output");

  a_keying_type: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.keying_select_pin_select == $past(w0[rfcw_pkg::KEYING_BIT]))
    else $error("keying type bit not carried to output");

  a_data_sense: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_ref_cfg.input_data_sense == $past(w0[rfcw_pkg::SENSE_BIT]))
    else $error("data sense bit not carried to output");

  a_osc_current: assert property (@(posedge clk) disable iff (!nrst)
    ##1 {tx_ref_cfg.osc_current_ceiling, tx_ref_cfg.osc_current_floor}
      == $past(w1[rfcw_pkg::OSC_FLOOR_LO +: 6]))
    else $error("oscillator current fields not carried to output");

  a_delayed_start: assert property (@(posedge clk) disable iff (!nrst)
    ##1 tx_ref_cfg.synth_delayed_start == $past(w1[rfcw_pkg::DELAY_BIT]))
    else $error("delayed start bit not carried to output");

  a_vco_bias: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_fb_cfg.vco_bias_level == $past(w2[rfcw_pkg::VCO_BIAS_LO +: 2]))
    else $error("vco bias field not carried to output");

  a_detector_sense: assert property (@(posedge clk) disable iff (!nrst)
    ##1 rx_fb_cfg.phase_detector_sense == $past(w2[rfcw_pkg::PD_SENSE_BIT]))
    else $error("detector polarity not carried to output");

  a_lock_window: assert property (@(posedge clk) disable iff (!nrst)
    ##1 tx_fb_cfg.lock_error_window == $past(w3[rfcw_pkg::ERR_WIN_LO +: 2]))
    else $error("lock error window not carried to output");

  a_settle_count: assert property (@(posedge clk) disable iff (!nrst)
    ##1 tx_fb_cfg.lock_settle_count == $past(w3[rfcw_pkg::SETTLE_LO +: 2]))
    else $error("lock settle count not carried to output");

  a_keying_source: assert property (@(posedge clk) disable iff (!nrst)
    ##1 tx_fb_cfg.keying_source_select == $past(w3[rfcw_pkg::KEY_SRC_BIT]))
    else $error("keying source bit not carried to output");

  a_mode_decode: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (active_mode == rfcw_pkg::RFCW_TRANSMIT) == ($past(w0[11:10]) == rfcw_pkg::MODE_TRANSMIT))
    else $error("transmit mode decode wrong");

  a_gain_source: assert property (@(posedge clk) disable iff (!nrst)
    !w2[21] |=> !amp_gain_int_high)
    else $error("gain request with external source");

  a_load_pulse: assert property (@(posedge clk) disable iff (!nrst)
    load_done |=> !load_done)
    else $error("load pulse longer than one cycle");

  c_load_rx_ref: cover property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_RX_REF);
  c_load_tx_fb: cover property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_TX_FB);
  c_mode_receive: cover property (@(posedge clk) disable iff (!nrst)
    active_mode == rfcw_pkg::RFCW_RECEIVE);
  c_load_tx_ref: cover property (@(posedge clk) disable iff (!nrst)
    sld_rise && frame_addr == rfcw_pkg::ADDR_TX_REF);
  c_mode_transmit: cover property (@(posedge clk) disable iff (!nrst)
    active_mode == rfcw_pkg::RFCW_TRANSMIT);
endmodule : rfcw_top

//--- include/rfcw_pkg.sv
/*
  rfcw_pkg: constants and field carriers for the serial control word bank.
  Assumes a single system clock of 10 MHz and a slower serial link sampled on it.
*/
package rfcw_pkg;
  // ==========================================================================
  // frame layout
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 22;
  localparam int ADDR_HI    = 23;
  localparam int ADDR_LO    = 22;
  localparam int SYNC_DEPTH = 2;

  // word addresses
  localparam logic [1:0] ADDR_RX_REF = 2'h0;
  localparam logic [1:0] ADDR_TX_REF = 2'h1;
  localparam logic [1:0] ADDR_RX_FB  = 2'h2;
  localparam logic [1:0] ADDR_TX_FB  = 2'h3;
  localparam int         NUM_WORDS   = 4;

  // field positions inside the 22-bit data field
  localparam int REF_DIV_MSB   = 9;  // reference dividers 9:0
  localparam int MODE_LO       = 10; // active mode 11:10
  localparam int AMP_GAIN_BIT  = 12;
  localparam int MIX_GAIN_BIT  = 13;
  localparam int TX_LEVEL_LO   = 14; // transmit level 15:14
  localparam int AUTOSTART_BIT = 16;
  localparam int LOCK_MODE_BIT = 17;
  localparam int PUMP_BIT      = 18;
  localparam int KEYING_BIT    = 19;
  localparam int SENSE_BIT     = 20;
  localparam int OSC_FLOOR_LO  = 10; // oscillator floor 12:10
  localparam int OSC_CEIL_LO   = 13; // oscillator ceiling 15:13
  localparam int HYST_BIT      = 18;
  localparam int DELAY_BIT     = 19;
  localparam int FB_DIV_MSB    = 16; // feedback dividers 16:0
  localparam int BAND_BIT      = 17;
  localparam int VCO_BIAS_LO   = 18; // vco bias 19:18
  localparam int PD_SENSE_BIT  = 20;
  localparam int GAIN_SRC_BIT  = 21;
  localparam int ERR_WIN_LO    = 17; // lock error window 18:17
  localparam int SETTLE_LO     = 19; // lock settle count 20:19
  localparam int KEY_SRC_BIT   = 21;

  // reset value of all four words, all clear
  localparam logic [21:0] WORD_RESET = 22'h000000;

  // ==========================================================================
  // active mode codes
  localparam logic [1:0] MODE_STANDBY  = 2'h0;
  localparam logic [1:0] MODE_RECEIVE  = 2'h1;
  localparam logic [1:0] MODE_TRANSMIT = 2'h2;
  localparam logic [1:0] MODE_IDLE     = 2'h3;

  typedef enum logic [1:0] {
    RFCW_STANDBY, RFCW_RECEIVE, RFCW_TRANSMIT, RFCW_IDLE
  } rfcw_mode_e;

  // ==========================================================================
  // decoded fields of the first, second, third and fourth words
  typedef struct packed {
    logic       input_data_sense;    // 1 inverse
    logic       keying_select_pin_select;      // 1 fsk
    logic       pump_current_select; // 1 high current
    logic       lock_mode;           // 1 before and after lock
    logic       amp_autostart_disable;
    logic [1:0] tx_level_field;
    logic       mixer_gain_select;
    logic       amp_gain_select;
    logic [1:0] active_mode_field;
    logic [9:0] rx_ref_divider;
  } rfcw_rx_ref_s;

  typedef struct packed {
    logic       synth_delayed_start;
    logic       amp_hysteresis_enable;
    logic [2:0] osc_current_ceiling;
    logic [2:0] osc_current_floor;
    logic [9:0] tx_ref_divider;
  } rfcw_tx_ref_s;

  typedef struct packed {
    logic        amp_gain_source;     // 1 internal
    logic        phase_detector_sense;// 1 positive
    logic [1:0]  vco_bias_level;
    logic        band_select;
    logic [16:0] rx_feedback_divider;
  } rfcw_rx_fb_s;

  typedef struct packed {
    logic        keying_source_select; // 1 internal
    logic [1:0]  lock_settle_count;
    logic [1:0]  lock_error_window;
    logic [16:0] tx_feedback_divider;
  } rfcw_tx_fb_s;
endpackage : rfcw_pkg

//--- sim/rfcw_host_model.sv
/*
  rfcw_host_model: host side of the three-wire control link.
  Assumes clk only paces the link; one link period is 8 clk (800 ns).
*/
`timescale 1ns/1ns
module rfcw_host_model (
  input  wire logic clk,  // pacing clock
  output logic      sclk, // link clock, low between frames
  output logic      sdat, // link data
  output logic      sld   // load strobe
);
  // ==========================================================================
  // idle levels from time zero
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    sld  = 1'b0;
  end

  // shift nbits msb first, then pulse the strobe well after the last rise
  task automatic send(input logic [31:0] frame, input int nbits);
    @(posedge clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      #1 sdat = frame[i];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
    end
    sdat = ~sdat; // released line shows no stale bit
    repeat (4) @(posedge clk);
    #1 sld = 1'b1;
    repeat (2) @(posedge clk);
    #1 sld = 1'b0;
  endtask : send
endmodule : rfcw_host_model

//--- sim/test_rfcw_top.sv
/*
  test_rfcw_top: self-checking bench for the control word bank.
  Assumes rfcw_host_model drives the link and clk runs at 10 MHz.
*/
`timescale 1ns/1ns
module test_rfcw_top;
  logic                   clk, nrst, sclk, sdat, sld;
  rfcw_pkg::rfcw_rx_ref_s rx_ref_cfg;
  rfcw_pkg::rfcw_tx_ref_s tx_ref_cfg;
  rfcw_pkg::rfcw_rx_fb_s  rx_fb_cfg;
  rfcw_pkg::rfcw_tx_fb_s  tx_fb_cfg;
  rfcw_pkg::rfcw_mode_e   active_mode;
  logic                   amp_gain_int_high, load_done;
  logic [21:0]            w [4];
  int                     bad_count, checked, cycles;

  rfcw_top u_dut (.clk(clk), .nrst(nrst), .serial_clock_line(sclk),
    .serial_data_line(sdat), .serial_load_strobe(sld), .rx_ref_cfg(rx_ref_cfg),
    .tx_ref_cfg(tx_ref_cfg), .rx_fb_cfg(rx_fb_cfg), .tx_fb_cfg(tx_fb_cfg),
    .active_mode(active_mode), .amp_gain_int_high(amp_gain_int_high),
    .load_done(load_done));
  rfcw_host_model u_host (.clk(clk), .sclk(sclk), .sdat(sdat), .sld(sld));

  // ==========================================================================
  // compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // all outputs but load_done against the expected words
  task automatic chk_all;
    chk(32'(rx_ref_cfg[12:0]), 32'(w[0][12:0]));
    chk(32'(rx_ref_cfg[16:13]), 32'(w[0][16:13]));
    chk(32'(rx_ref_cfg[20:17]), 32'(w[0][20:17]));
    chk(32'(tx_ref_cfg), 32'({w[1][19:18], w[1][15:0]}));
    chk(32'(rx_fb_cfg), 32'(w[2]));
    chk(32'(tx_fb_cfg), 32'(w[3]));
    chk(32'(active_mode), 32'(w[0][11:10]));
    chk(32'(amp_gain_int_high), 32'(w[2][21] & w[0][12]));
  endtask : chk_all

  // one frame, wait for the load pulse, then compare everything
  task automatic wr(input logic [31:0] f, input int nbits);
    int n;
    u_host.send(f, nbits);
    n = 0;
    while (load_done !== 1'b1 && n < 12) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(32'(load_done), 32'h1);
    w[f[23:22]] = f[21:0];
    @(posedge clk);
    #2;
    chk(32'(load_done), 32'h0); // pulse lasts one cycle
    chk_all();
  endtask : wr

  // closing report
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // test sequence
  initial begin
    logic [21:0] d;
    nrst = 1'b0;
    for (int i = 0; i < 4; i++) w[i] = 22'h0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #2 chk_all();
    $display("test reset done");
    // every word, complementary patterns, test bits of word two kept clear
    for (int i = 0; i < 8; i++) begin
      d = i[2] ? 22'h155555 : 22'h2aaaaa;
      if (i[1:0] == 2'h1) d = d & 22'h3cffff;
      wr({8'h00, i[1:0], d}, 24);
    end
    $display("test patterns done");
    // every mode code with gain bit both ways, internal gain source on
    wr({8'h00, 2'h2, 22'h200000}, 24);
    for (int m = 0; m < 8; m++) wr({8'h00, 2'h0, 9'h0, m[2], m[1:0], 10'h155}, 24);
    $display("test modes done");
    // leading bits beyond the frame are dropped
    wr({4'hb, 2'h3, 22'h0abcde}, 28);
    $display("test long frame done");
    // reset in mid-run clears every word
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 4; i++) w[i] = 22'h0;
    repeat (4) @(posedge clk);
    #2 chk_all();
    wr({8'h00, 2'h1, 22'h0c3a5f}, 24);
    $display("test second reset done");
    give_verdict();
  end
endmodule : test_rfcw_top
